/* design/issue_sched_regs.svh */
// Purpose: Constants for the dual-issue scoreboard (latencies, opcode groups)
// Assumes: Latencies in issue cycles of the core clock
// Notes: Latency values are counts of cycles after the producer issued
`ifndef ISSUE_SCHED_REGS_SVH
`define ISSUE_SCHED_REGS_SVH
`define LAT_INT_FAST 6'd1
`define LAT_INT_SHIFT 6'd2
`define LAT_LOAD 6'd3
`define LAT_ZERO 6'd0
`define LAT_MUL_DEP 6'd21
`define LAT_MUL_IND 6'd19
`define LAT_FLOAT_OP 6'd6
`define LAT_DIV_DEP 6'd34
`define LAT_DIV_IND 6'd30
`define MUL_BLOCK_AHEAD 6'd3
`define DIV_BLOCK_A 6'd5
`define DIV_BLOCK_B 6'd6
`define COND_STORE_GAP 2'd2
`define OP_LOAD_F 6'h20
`define OP_LOAD_I 6'h28
`define OP_INT_ARITH 6'h10
`define OP_BRANCH_GRP 6'h30
`endif

/* design/issue_sched_pkg.sv */
// Purpose: Types for the dual-issue scoreboard
// Assumes: Classes are decoded upstream
// Notes: Bus codes describe which issue bus an opcode may use
`default_nettype none
package issue_sched_pkg;
    typedef enum logic [3:0] {
        load_class = 4'h0,
        memory_write_class = 4'h1,
        int_cond_branch_class = 4'h2,
        float_cond_branch_class = 4'h3,
        jump_subroutine_class = 4'h4,
        int_add_logic_class = 4'h5,
        shift_cmove_class = 4'h6,
        int_compare_class = 4'h7,
        int_multiply_class = 4'h8,
        float_operate_class = 4'h9,
        float_divide_class = 4'ha,
        misc_class = 4'hb
    } iclass_t;
    typedef enum logic [1:0] {
        issue_bus_a = 2'b01,
        issue_bus_b = 2'b10,
        issue_bus_either = 2'b11
    } ibus_t;
endpackage
`default_nettype wire

/* design/dual_issue_scoreboard.sv */
// Purpose: Name holder only; the scoreboard module is in dual_issue_scoreboard_core.sv
// Assumes: Build lists may name this file; it declares nothing
// Notes: Kept empty so the scoreboard module is declared exactly once
`default_nettype none
`default_nettype wire

/* design/dual_issue_scoreboard_core.sv */
// Purpose: Issue-stage hazard and pairing logic for two candidate instructions
// Assumes: Decode supplies class, opcode, registers and flags per slot
// Notes: Slot 0 is older; slot 1 issues only alongside slot 0
`include "issue_sched_regs.svh"
`default_nettype none

module dual_issue_scoreboard #(
    parameter int NREG = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] slot_valid,
    input wire issue_sched_pkg::iclass_t slot0_class,
    input wire issue_sched_pkg::iclass_t slot1_class,
    input wire logic [5:0] slot0_opcode,
    input wire logic [5:0] slot1_opcode,
    input wire logic [5:0] slot0_src_a,
    input wire logic [5:0] slot1_src_a,
    input wire logic [5:0] slot0_src_b,
    input wire logic [5:0] slot1_src_b,
    input wire logic [5:0] slot0_dst,
    input wire logic [5:0] slot1_dst,
    input wire logic [1:0] slot_is_fence,
    input wire logic [1:0] slot_is_trap_barrier,
    input wire logic [1:0] slot_is_reg_move,
    input wire logic [1:0] slot_is_priv_return,
    input wire logic [1:0] slot_is_store_cond,
    input wire logic [1:0] slot_is_cycle_ctr,
    input wire logic [1:0] slot_writes_link,
    input wire logic same_quadword,
    input wire logic fence_ack,
    input wire logic addr_unit_busy,
    input wire logic load_miss,
    output logic [1:0] issue,
    output logic nop_insert,
    output logic fence_pending
);
    // Registers 0..31 integer, 32..63 float; register 31 and 63 never hazard.
    typedef logic [5:0] lat_t;

    // =========================================================
    // Scoreboard state
    // =========================================================
    lat_t age_ff [NREG];
    issue_sched_pkg::iclass_t prod_ff [NREG];
    logic [NREG-1:0] pend_ff;
    logic [NREG-1:0] miss_ff;
    lat_t mul_left_ff;
    lat_t div_left_ff;
    logic fence_ff;
    logic [1:0] cond_store_gap_ff;
    logic after_jump_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic busy_s1_ff;
    logic busy_s2_ff;
    logic miss_s1_ff;
    logic miss_s2_ff;

    // =========================================================
    // Functions
    // =========================================================
    function automatic logic is_real(input logic [5:0] r);
        is_real = (r != 6'd31) && (r != 6'd63);
    endfunction

    // Producer-to-consumer latency; base selects store base vs data.
    function automatic lat_t lat_of(input issue_sched_pkg::iclass_t p,
                                    input issue_sched_pkg::iclass_t c,
                                    input logic base);
        lat_of = `LAT_INT_FAST;
        case (p)
            issue_sched_pkg::load_class: lat_of = `LAT_LOAD;
            issue_sched_pkg::jump_subroutine_class: lat_of = `LAT_LOAD;
            issue_sched_pkg::int_add_logic_class, issue_sched_pkg::shift_cmove_class,
            issue_sched_pkg::int_compare_class: begin
                if (c == issue_sched_pkg::memory_write_class) begin
                    lat_of = base ? `LAT_INT_SHIFT : `LAT_ZERO;
                end else if (p == issue_sched_pkg::int_add_logic_class) begin
                    lat_of = `LAT_INT_FAST;
                end else begin
                    lat_of = `LAT_INT_SHIFT;
                end
            end
            issue_sched_pkg::int_multiply_class: lat_of = `LAT_MUL_DEP;
            issue_sched_pkg::float_operate_class: lat_of = `LAT_FLOAT_OP;
            issue_sched_pkg::float_divide_class: lat_of = `LAT_DIV_DEP;
            default: lat_of = `LAT_INT_FAST;
        endcase
    endfunction

    function automatic issue_sched_pkg::ibus_t bus_of(input logic [5:0] op);
        logic [2:0] grp;
        grp = op[5:3];
        bus_of = issue_sched_pkg::issue_bus_b;
        if (op == `OP_LOAD_F || op == `OP_LOAD_I) begin
            bus_of = issue_sched_pkg::issue_bus_either;
        end else if (grp == 3'd4) begin
            bus_of = op[2] ? issue_sched_pkg::issue_bus_a : issue_sched_pkg::issue_bus_either;
        end else if (grp == 3'd5) begin
            bus_of = op[2] ? issue_sched_pkg::issue_bus_b : issue_sched_pkg::issue_bus_either;
        end else if (grp == 3'd2) begin
            bus_of = (op[2:0] < 3'd4) ? issue_sched_pkg::issue_bus_a
                                       : issue_sched_pkg::issue_bus_b;
        end else if (grp == 3'd1) begin
            bus_of = (op == 6'h08 || op == 6'h09) ? issue_sched_pkg::issue_bus_a
                   : (op == 6'h0b) ? issue_sched_pkg::issue_bus_either
                   : issue_sched_pkg::issue_bus_b;
        end else if (grp == 3'd6) begin
            bus_of = (op[2:0] == 3'd0 || op[2:0] == 3'd4) ? issue_sched_pkg::issue_bus_b
                                                          : issue_sched_pkg::issue_bus_a;
        end
    endfunction

    // True when this source is ready for use by class c.
    function automatic logic src_ok(input logic [5:0] r, input issue_sched_pkg::iclass_t c,
                                    input logic base, input lat_t age,
                                    input issue_sched_pkg::iclass_t p, input logic pend,
                                    input logic miss);
        src_ok = 1'b1;
        if (is_real(r) && pend) begin
            src_ok = !miss && (age >= lat_of(p, c, base));
        end
    endfunction

    // =========================================================
    // Per-slot hazard checks
    // =========================================================
    issue_sched_pkg::iclass_t cls [2];
    logic [5:0] op [2];
    logic [5:0] sa [2];
    logic [5:0] sb [2];
    logic [5:0] ds [2];
    logic [1:0] ok;
    logic [1:0] memtype;
    logic [1:0] ctl;
    logic [1:0] onemem;
    logic pair_ok;
    logic dep10;
    lat_t dep_lat;

    always_comb begin
        cls[0] = slot0_class;
        cls[1] = slot1_class;
        op[0] = slot0_opcode;
        op[1] = slot1_opcode;
        sa[0] = slot0_src_a;
        sa[1] = slot1_src_a;
        sb[0] = slot0_src_b;
        sb[1] = slot1_src_b;
        ds[0] = slot0_dst;
        ds[1] = slot1_dst;
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            memtype[i] = cls[i] == issue_sched_pkg::load_class
                || cls[i] == issue_sched_pkg::memory_write_class || slot_is_fence[i]
                || slot_is_cycle_ctr[i] || slot_is_trap_barrier[i] || slot_is_reg_move[i]
                || slot_writes_link[i];
            ctl[i] = cls[i] == issue_sched_pkg::jump_subroutine_class
                || cls[i] == issue_sched_pkg::int_cond_branch_class
                || cls[i] == issue_sched_pkg::float_cond_branch_class
                || slot_is_priv_return[i] || op[i][5:3] == 3'd6 && op[i][1:0] == 2'd0;
            onemem[i] = memtype[i] || cls[i] == issue_sched_pkg::misc_class
                || slot_is_priv_return[i] || ctl[i] && !(op[i][5:3] == 3'd6 && op[i][2:0] != 3'd0
                && op[i][2:0] != 3'd4) && cls[i] != issue_sched_pkg::int_cond_branch_class
                && cls[i] != issue_sched_pkg::float_cond_branch_class;
            ok[i] = slot_valid[i];
            // Source readiness, store base on src_b
            if (!src_ok(sa[i], cls[i], 1'b0, age_ff[sa[i]], prod_ff[sa[i]], pend_ff[sa[i]],
                        miss_ff[sa[i]])) ok[i] = 1'b0;
            if (!src_ok(sb[i], cls[i], cls[i] == issue_sched_pkg::memory_write_class
                        || cls[i] == issue_sched_pkg::load_class, age_ff[sb[i]],
                        prod_ff[sb[i]], pend_ff[sb[i]], miss_ff[sb[i]])) ok[i] = 1'b0;
            // Late writers keep write order
            if (is_real(ds[i]) && pend_ff[ds[i]] && (miss_ff[ds[i]]
                || (prod_ff[ds[i]] == issue_sched_pkg::int_multiply_class
                    || prod_ff[ds[i]] == issue_sched_pkg::float_divide_class
                    || prod_ff[ds[i]] == issue_sched_pkg::load_class)
                && age_ff[ds[i]] < lat_of(prod_ff[ds[i]], cls[i], 1'b0))) ok[i] = 1'b0;
            if (memtype[i] && fence_ff) ok[i] = 1'b0;
            if (memtype[i] && busy_s2_ff) ok[i] = 1'b0;
            // Float base holds the slot; decode must never send one
            if ((cls[i] == issue_sched_pkg::load_class
                 || cls[i] == issue_sched_pkg::memory_write_class) && sb[i][5] && is_real(sb[i]))
                ok[i] = 1'b0;
            if (cls[i] == issue_sched_pkg::int_multiply_class && mul_left_ff != 6'd0)
                ok[i] = 1'b0;
            if ((cls[i] == issue_sched_pkg::int_add_logic_class
                 || cls[i] == issue_sched_pkg::shift_cmove_class
                 || cls[i] == issue_sched_pkg::int_compare_class)
                && mul_left_ff == `MUL_BLOCK_AHEAD) ok[i] = 1'b0;
            if ((cls[i] == issue_sched_pkg::int_cond_branch_class
                 || cls[i] == issue_sched_pkg::float_cond_branch_class) && after_jump_ff)
                ok[i] = 1'b0;
            if (cls[i] == issue_sched_pkg::load_class && cond_store_gap_ff != 2'd0)
                ok[i] = 1'b0;
            if (cls[i] == issue_sched_pkg::float_divide_class && div_left_ff != 6'd0)
                ok[i] = 1'b0;
            if ((cls[i] == issue_sched_pkg::float_operate_class)
                && (div_left_ff == `DIV_BLOCK_A || div_left_ff == `DIV_BLOCK_B))
                ok[i] = 1'b0;
        end
    end

    // =========================================================
    // Pairing
    // =========================================================
    always_comb begin
        dep10 = is_real(ds[0]) && (ds[0] == sa[1] || ds[0] == sb[1]);
        dep_lat = lat_of(cls[0], cls[1], cls[1] == issue_sched_pkg::memory_write_class
                         && ds[0] == sb[1]);
        pair_ok = same_quadword
            && ((bus_of(op[0]) | bus_of(op[1])) == issue_sched_pkg::issue_bus_either)
            && !(bus_of(op[0]) == bus_of(op[1]) && bus_of(op[0])
                 != issue_sched_pkg::issue_bus_either)
            && !slot_is_trap_barrier[1]
            && !(ctl[0] && ctl[1])
            && !(onemem[0] && onemem[1])
            && !(dep10 && dep_lat != `LAT_ZERO)
            && !(is_real(ds[0]) && ds[0] == ds[1]);
        issue[0] = ok[0];
        issue[1] = ok[0] && ok[1] && pair_ok;
        nop_insert = slot_valid[0] && !ok[0];
    end

    // =========================================================
    // Synchronisers for unit status pins
    // =========================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            busy_s1_ff <= 1'b0;
            busy_s2_ff <= 1'b0;
            miss_s1_ff <= 1'b0;
            miss_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= fence_ack;
            ack_s2_ff <= ack_s1_ff;
            busy_s1_ff <= addr_unit_busy;
            busy_s2_ff <= busy_s1_ff;
            miss_s1_ff <= load_miss;
            miss_s2_ff <= miss_s1_ff;
        end
    end

    // =========================================================
    // Register scoreboard
    // =========================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_ff <= '0;
            miss_ff <= '0;
            for (int r = 0; r < NREG; r++) begin
                age_ff[r] <= 6'd0;
                prod_ff[r] <= issue_sched_pkg::int_add_logic_class;
            end
        end else begin
            for (int r = 0; r < NREG; r++) begin
                if (pend_ff[r] && age_ff[r] != 6'h3f) age_ff[r] <= age_ff[r] + 6'd1;
                if (pend_ff[r] && age_ff[r] >= 6'd63) pend_ff[r] <= 1'b0;
                // Missed loads hold their consumers until the fill lands
                if (miss_ff[r] && !miss_s2_ff) miss_ff[r] <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (issue[i] && is_real(ds[i])) begin
                    pend_ff[ds[i]] <= 1'b1;
                    age_ff[ds[i]] <= 6'd1;
                    prod_ff[ds[i]] <= cls[i];
                    miss_ff[ds[i]] <= 1'b0;
                end
            end
            if (miss_s2_ff) begin
                for (int r = 0; r < NREG; r++) begin
                    if (pend_ff[r] && prod_ff[r] == issue_sched_pkg::load_class
                        && age_ff[r] < `LAT_LOAD) miss_ff[r] <= 1'b1;
                end
            end
        end
    end

    // =========================================================
    // Unit counters and one-shot windows
    // =========================================================
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mul_left_ff <= 6'd0;
            div_left_ff <= 6'd0;
            cond_store_gap_ff <= 2'd0;
            after_jump_ff <= 1'b0;
        end else begin
            mul_left_ff <= (mul_left_ff != 6'd0) ? mul_left_ff - 6'd1 : 6'd0;
            div_left_ff <= (div_left_ff != 6'd0) ? div_left_ff - 6'd1 : 6'd0;
            cond_store_gap_ff <= (cond_store_gap_ff != 2'd0) ? cond_store_gap_ff - 2'd1 : 2'd0;
            after_jump_ff <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (issue[i]) begin
                    if (cls[i] == issue_sched_pkg::int_multiply_class)
                        mul_left_ff <= `LAT_MUL_IND - 6'd1;
                    if (cls[i] == issue_sched_pkg::float_divide_class)
                        div_left_ff <= `LAT_DIV_IND - 6'd1;
                    if (slot_is_store_cond[i]) cond_store_gap_ff <= `COND_STORE_GAP;
                    if (cls[i] == issue_sched_pkg::jump_subroutine_class
                        || slot_is_priv_return[i]) after_jump_ff <= 1'b1;
                end
            end
        end
    end

    // Fence: set wins over a same-cycle acknowledge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fence_ff <= 1'b0;
        end else if ((issue[0] && slot_is_fence[0]) || (issue[1] && slot_is_fence[1])) begin
            fence_ff <= 1'b1;
        end else if (ack_s2_ff) begin
            fence_ff <= 1'b0;
        end
    end

    assign fence_pending = fence_ff;
endmodule
`default_nettype wire

/* verif/fence_port_model.sv */
// Purpose: Data port model that acknowledges ordering fences
// Assumes: Acknowledge holds while the fence stays pending
// Notes: Delay input lets the bench answer promptly or slowly
`default_nettype none
module fence_port_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic fence_pending,
    input wire logic [3:0] delay,
    output logic fence_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_ff <= 4'h0;
        end else begin
            wait_ff <= fence_pending ? wait_ff + 4'(wait_ff != delay) : 4'h0;
        end
    end
    assign fence_ack = fence_pending && wait_ff == delay;
endmodule
`default_nettype wire

/* verif/dual_issue_scoreboard_sva.sv */
// Purpose: Issue output checks
// Assumes: One clock domain
// Notes: Class codes follow the package encoding
`default_nettype none
module dual_issue_scoreboard_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] slot_valid,
    input wire issue_sched_pkg::iclass_t slot0_class,
    input wire issue_sched_pkg::iclass_t slot1_class,
    input wire logic [1:0] slot_is_store_cond,
    input wire logic same_quadword,
    input wire logic [1:0] issue,
    input wire logic nop_insert,
    input wire logic fence_pending
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic load0 = issue[0] && slot0_class == 4'h0;
    wire logic mul0 = issue[0] && slot0_class == 4'h8;
    wire logic ctl2 = slot0_class inside {[4'h2:4'h4]} && slot1_class inside {[4'h2:4'h4]};
    wire logic mem2 = slot0_class inside {4'h0, 4'h1, 4'h4, 4'hb}
        && slot1_class inside {4'h0, 4'h1, 4'h4, 4'hb};
    property p_order; issue[1] |-> issue[0] && slot_valid == 2'h3; endproperty
    a_order: assert property (p_order) else $error("order");
    property p_nop; nop_insert == (slot_valid[0] && !issue[0]); endproperty
    a_nop: assert property (p_nop) else $error("nop");
    property p_quad; !same_quadword |-> !issue[1]; endproperty
    a_quad: assert property (p_quad) else $error("quad");
    property p_ctl; ctl2 |-> !issue[1]; endproperty
    a_ctl: assert property (p_ctl) else $error("ctl");
    property p_mem; mem2 |-> !issue[1]; endproperty
    a_mem: assert property (p_mem) else $error("mem");
    property p_mul; mul0 |=> !mul0 [*8]; endproperty
    a_mul: assert property (p_mul) else $error("mul");
    property p_cond_store; issue[0] && slot_is_store_cond[0] |=> !load0 [*2]; endproperty
    a_cond_store: assert property (p_cond_store) else $error("cond store");
    property p_fence; fence_pending |-> !load0; endproperty
    a_fence: assert property (p_fence) else $error("fence");
endmodule
bind dual_issue_scoreboard dual_issue_scoreboard_sva sva_i (.*);
`default_nettype wire

/* verif/dual_issue_scoreboard_bench.sv */
// Purpose: Self-checking bench for the dual-issue scoreboard
// Assumes: Clean scoreboard after each idle gap
// Notes: Move, link, counter and miss inputs stay low
`default_nettype none
module dual_issue_scoreboard_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rst = 1, same_quadword = 0, addr_unit_busy = 0, load_miss = 0;
    logic nop_insert, fence_pending, fence_ack;
    logic [1:0] slot_valid = 2'h0, slot_is_fence = 2'h0, slot_is_trap_barrier = 2'h0, issue;
    logic [1:0] slot_is_reg_move = 2'h0, slot_is_priv_return = 2'h0, slot_is_store_cond = 2'h0;
    logic [1:0] slot_is_cycle_ctr = 2'h0, slot_writes_link = 2'h0;
    issue_sched_pkg::iclass_t slot0_class = issue_sched_pkg::misc_class;
    issue_sched_pkg::iclass_t slot1_class = issue_sched_pkg::misc_class;
    logic [5:0] slot0_opcode = 6'h0, slot1_opcode = 6'h0, slot0_src_a = 6'h0, slot1_src_a = 6'h0;
    logic [5:0] slot0_src_b = 6'h0, slot1_src_b = 6'h0, slot0_dst = 6'h0, slot1_dst = 6'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] seed = 32'h38;
    int fail_count = 0, cmp_count = 0, n, i, j, b;
    // Add shift mul float-op load store float-store int-branch float-branch jump misc
    int cl[11] = '{5, 6, 8, 9, 0, 1, 1, 2, 3, 4, 11};
    int op[11] = '{6'h10, 6'h12, 6'h13, 6'h16, 6'h28, 6'h2d, 6'h26, 6'h39, 6'h31, 6'h1a, 6'h18};
    int bu[11] = '{1, 1, 1, 2, 3, 2, 1, 2, 1, 2, 2};
    int tp[6] = '{0, 1, 1, 2, 2, 5}, tc[6] = '{1, 0, 5, 2, 2, 4};
    int td[6] = '{1, 1, 2, 0, 1, 0}, te[6] = '{1, 2, 2, 19, 21, 3};
    dual_issue_scoreboard DUT (.*);
    fence_port_model port_i (.clock, .rst, .fence_pending, .delay(dly), .fence_ack);
    always #4 clock = ~clock;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic pair_ok(input int i, j);
        return (bu[i] | bu[j]) == 3 && !(cl[i] inside {[2:4]} && cl[j] inside {[2:4]})
            && !(cl[i] inside {0, 1, 4, 11} && cl[j] inside {0, 1, 4, 11});
    endfunction
    task check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task results();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task put(input int s, k, d, a, c);
        if (s == 0) begin
            slot0_class <= issue_sched_pkg::iclass_t'(cl[k]);
            slot0_opcode <= 6'(op[k]);
            {slot0_dst, slot0_src_a, slot0_src_b} <= {6'(d), 6'(a), 6'(c)};
        end else begin
            slot1_class <= issue_sched_pkg::iclass_t'(cl[k]);
            slot1_opcode <= 6'(op[k]);
            {slot1_dst, slot1_src_a, slot1_src_b} <= {6'(d), 6'(a), 6'(c)};
        end
    endtask
    // Cycles from producer issue to consumer issue land in n
    task lat(input int p, c, dep, input logic [1:0] fl);
        @(posedge clock);
        put(0, p, 7, 2, 3);
        {slot_is_store_cond[0], slot_is_fence[0]} <= fl;
        slot_valid <= 2'h1;
        @(posedge clock);
        put(0, c, 9, dep == 1 ? 7 : 5, dep == 2 ? 7 : 6);
        {slot_is_store_cond[0], slot_is_fence[0]} <= 2'h0;
        n = 1;
        @(negedge clock);
        while (issue[0] !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        slot_valid <= 2'h0;
        repeat (24) @(posedge clock);
    endtask
    task pair(input int i, j, a, q, t, b);
        logic e0;
        logic e1;
        e0 = !(b && i inside {[4:6]});
        // Busy address unit holds a memory-type second slot as well
        e1 = e0 && !(b && j inside {[4:6]}) && pair_ok(i, j) && q && !t;
        addr_unit_busy <= b[0];
        repeat (4) @(posedge clock);
        put(0, i, 7, 2, 3);
        put(1, j, 4, a, 6);
        same_quadword <= q[0];
        slot_is_trap_barrier <= {t[0], 1'b0};
        slot_valid <= 2'h3;
        @(negedge clock);
        check(issue, {e1, e0});
        @(posedge clock);
        slot_valid <= 2'h0;
        addr_unit_busy <= 1'b0;
        repeat (22) @(posedge clock);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            lat(tp[k], tc[k], td[k], k == 5 ? 2'h2 : 2'h0);
            check(n, te[k]);
        end
        for (int k = 0; k < 2; k++) begin
            dly <= 4'(k * 9);
            lat(10, 4, 0, 2'h1);
            check(n > dly + 2 && n < dly + 9, 1);
        end
        pair(0, 5, 7, 1, 0, 0);
        repeat (60) begin
            i = xs() % 11;
            j = xs() % 11;
            b = i < 9 && xs() % 4 == 0;
            pair(i, j, 5, xs() % 2, j == 10 && xs() % 2, b);
        end
        results();
    end
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule
`default_nettype wire
